// ===== atfe_cmp_model.sv
`timescale 1ns/1ps
module atfe_cmp_model (
  input  wire logic [7:0] code_high_in,
  input  wire logic [7:0] code_low_in,
  input  wire logic       pin_sel_in,
  input  wire logic       amp_path_in,
  input  wire logic [7:0] pin_level_in,
  input  wire logic [7:0] amp_level_in,
  output logic            cmp_high_out,
  output logic            cmp_low_out
);
  // ************************************************************
  // Source choice and threshold comparison
  // ************************************************************
  // The source input rests at the bottom of the scale if no path is chosen.
  wire logic [7:0] src_lvl = pin_sel_in ? pin_level_in :
                             (amp_path_in ? amp_level_in : 8'h00);
  // Code 0x00 is the top of the scale and 0xff the bottom.
  wire logic [7:0] thr_high = 8'hff - code_high_in;
  wire logic [7:0] thr_low  = 8'hff - code_low_in;
  // Comparators settle a little after their inputs move, off the clock edge.
  assign #1 cmp_high_out = src_lvl > thr_high;
  assign #1 cmp_low_out  = src_lvl > thr_low;
endmodule

// ===== atfe_front_end.sv
`timescale 1ns/1ps
module atfe_front_end
  import atfe_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic [31:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [31:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        shared_trigger_pin_in,
  input  wire logic        cmp_high_in,
  input  wire logic        cmp_low_in,
  output logic [7:0]       threshold_dac_a_out,
  output logic [7:0]       threshold_dac_b_out,
  output logic             source_pin_sel_out,
  output logic             gain_amp_path_out,
  output logic             pin_to_fi0_out,
  output logic             analog_trig_in0_out,
  output logic             analog_trig_in1_out,
  output logic             function_input_zero_out
);

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic reg_hit(input logic [31:0] addr);
    reg_hit = (addr == ADDR_CTRL) || (addr == ADDR_THRESH) ||
              (addr == ADDR_STATUS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    merge = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
  endfunction

  // ************************************************************
  // Comparator synchroniser
  // ************************************************************
  logic [1:0] cmp_w;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;

  assign cmp_w = {cmp_low_in, cmp_high_in};

  // Two flops per bit; the comparators are asynchronous to the clock.
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
          sync1_q[i] <= 1'b0;
          sync2_q[i] <= 1'b0;
        end else begin
          sync1_q[i] <= cmp_w[i];
          sync2_q[i] <= sync1_q[i];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Registers
  // ************************************************************
  atfe_ctrl_t  ctrl_q;
  logic [7:0]  thr_a_q;
  logic [7:0]  thr_b_q;
  logic        trig_w;
  logic        pin_q;
  logic [31:0] ctrl_word_w;
  logic [31:0] thr_word_w;
  logic [31:0] stat_word_w;
  logic [31:0] ctrl_new_w;
  logic [31:0] thr_new_w;

  // Read views of the registers; unused bits read as zero.
  assign ctrl_word_w = {25'h0, ctrl_q.mode, 1'b0, ctrl_q.path,
                        ctrl_q.drive, ctrl_q.enable};
  assign thr_word_w  = {16'h0, thr_b_q, thr_a_q};
  assign stat_word_w = {28'h0, pin_q, trig_w, sync2_q[1], sync2_q[0]};

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        awready_d;
  logic        wready_d;
  logic        do_write_w;
  logic        aw_take_w;
  logic        w_take_w;

  assign awready_d  = s_axi_awvalid_in & ~s_axi_awready_out & ~aw_hold_q &
                      ~s_axi_bvalid_out;
  assign wready_d   = s_axi_wvalid_in & ~s_axi_wready_out & ~w_hold_q &
                      ~s_axi_bvalid_out;
  assign aw_take_w  = s_axi_awready_out & s_axi_awvalid_in;
  assign w_take_w   = s_axi_wready_out & s_axi_wvalid_in;
  assign do_write_w = aw_hold_q & w_hold_q & ~s_axi_bvalid_out;
  assign ctrl_new_w = merge(ctrl_word_w, wdata_q, wstrb_q);
  assign thr_new_w  = merge(thr_word_w, wdata_q, wstrb_q);

  // Address and data are taken in either order, then answered together.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      aw_hold_q         <= 1'b0;
      w_hold_q          <= 1'b0;
      awaddr_q          <= '0;
      wdata_q           <= '0;
      wstrb_q           <= '0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= RESP_OKAY;
    end else begin
      s_axi_awready_out <= awready_d;
      s_axi_wready_out  <= wready_d;
      if (aw_take_w) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_in;
      end
      if (w_take_w) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata_in;
        wstrb_q  <= s_axi_wstrb_in;
      end
      if (do_write_w) begin
        aw_hold_q        <= 1'b0;
        w_hold_q         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= reg_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Register update; reset leaves the pin as a plain digital input.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ctrl_q  <= CTRL_RST;
      thr_a_q <= THR_A_RST;
      thr_b_q <= THR_B_RST;
    end else if (do_write_w && awaddr_q == ADDR_CTRL) begin
      ctrl_q.enable <= ctrl_new_w[CTRL_EN_BIT];
      ctrl_q.drive  <= ctrl_new_w[CTRL_DRIVE_BIT];
      ctrl_q.path   <= ctrl_new_w[CTRL_PATH_BIT];
      ctrl_q.mode   <= atfe_mode_t'(ctrl_new_w[CTRL_MODE_LSB +: MODE_W]);
    end else if (do_write_w && awaddr_q == ADDR_THRESH) begin
      thr_a_q <= thr_new_w[THR_A_LSB +: CODE_W];
      thr_b_q <= thr_new_w[THR_B_LSB +: CODE_W];
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  logic        arready_d;
  logic [31:0] rd_mux_w;

  assign arready_d = s_axi_arvalid_in & ~s_axi_arready_out &
                     ~s_axi_rvalid_out;
  assign rd_mux_w  = (s_axi_araddr_in == ADDR_CTRL)   ? ctrl_word_w :
                     (s_axi_araddr_in == ADDR_THRESH) ? thr_word_w  :
                     (s_axi_araddr_in == ADDR_STATUS) ? stat_word_w :
                     32'h0000_0000;

  // One read at a time; unmapped reads give zero and a slave error.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= RESP_OKAY;
    end else begin
      s_axi_arready_out <= arready_d;
      if (s_axi_arready_out && s_axi_arvalid_in) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= rd_mux_w;
        s_axi_rresp_out  <= reg_hit(s_axi_araddr_in) ? RESP_OKAY
                                                     : RESP_SLVERR;
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Trigger detection and pin routing
  // ************************************************************
  atfe_trig_detect u_detect (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .above_high_in (sync2_q[0]),
    .above_low_in  (sync2_q[1]),
    .mode_in       (ctrl_q.mode),
    .enable_in     (ctrl_q.enable),
    .trig_out      (trig_w)
  );

  logic fi0_d;

  // Enabled trigger owns the slot; else the pin only if it is routed.
  assign fi0_d = ctrl_q.enable ? trig_w :
                 ctrl_q.drive  ? shared_trigger_pin_in : 1'b0;

  // All routing and level outputs are registered.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pin_q                   <= 1'b0;
      source_pin_sel_out      <= 1'b0;
      gain_amp_path_out       <= 1'b0;
      pin_to_fi0_out          <= 1'b0;
      analog_trig_in0_out     <= 1'b0;
      analog_trig_in1_out     <= 1'b0;
      function_input_zero_out <= 1'b0;
    end else begin
      pin_q                   <= shared_trigger_pin_in;
      source_pin_sel_out      <= ctrl_q.drive;
      gain_amp_path_out       <= ctrl_q.path;
      pin_to_fi0_out          <= ctrl_q.drive & ~ctrl_q.enable;
      analog_trig_in0_out     <= sync2_q[0];
      analog_trig_in1_out     <= sync2_q[1];
      function_input_zero_out <= fi0_d;
    end
  end

  // Codes go out unchanged; software keeps the trim mirror itself.
  assign threshold_dac_a_out = thr_a_q;
  assign threshold_dac_b_out = thr_b_q;

  // ************************************************************
  // Checks
  // ************************************************************
  logic [1:0] up_cnt_q;

  // Counts cycles since reset so the pipeline checks see real history.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      up_cnt_q <= 2'h0;
    end else if (up_cnt_q != 2'h3) begin
      up_cnt_q <= up_cnt_q + 2'h1;
    end
  end

  sequence s_both_held;
    aw_hold_q && w_hold_q && !s_axi_bvalid_out;
  endsequence

  a_bresp_after_both: assert property (@(posedge clk_sys_in)
    disable iff (reset_in) s_both_held |=> s_axi_bvalid_out)
    else $error("write response missing after address and data");

  a_src_select: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    ##1 source_pin_sel_out == $past(ctrl_q.drive))
    else $error("source select does not follow routing bit");

  a_path_select: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    ##1 gain_amp_path_out == $past(ctrl_q.path))
    else $error("gain path select does not follow path bit");

  a_fi0_pin_route: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    !ctrl_q.enable && ctrl_q.drive |=>
      function_input_zero_out == $past(shared_trigger_pin_in))
    else $error("routed pin does not reach function input zero");

  a_fi0_blocked: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    !ctrl_q.enable && !ctrl_q.drive |=> !function_input_zero_out)
    else $error("disconnected pin still reaches function input zero");

  a_fi0_takeover: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    ctrl_q.enable |=> function_input_zero_out == $past(trig_w) &&
                      !pin_to_fi0_out)
    else $error("analog trigger did not take over the pin slot");

  a_sync_depth: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    up_cnt_q == 2'h3 |-> analog_trig_in0_out == $past(cmp_high_in, 3) &&
                         analog_trig_in1_out == $past(cmp_low_in, 3))
    else $error("comparator bits not delayed by synchroniser");

  a_reset_clear: assert property (@(posedge clk_sys_in)
    reset_in |=> ctrl_q == CTRL_RST && !function_input_zero_out)
    else $error("reset did not clear trigger control");

  a_thr_write: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    do_write_w && awaddr_q == ADDR_THRESH && wstrb_q[0] |=>
      threshold_dac_a_out == $past(wdata_q[THR_A_LSB +: CODE_W]))
    else $error("threshold code not stored as written");

endmodule

// ===== atfe_pkg.sv
package atfe_pkg;

  // ************************************************************
  // Register map and field layout
  // ************************************************************
  localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] ADDR_THRESH = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;

  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_DRIVE_BIT = 1;
  localparam int unsigned CTRL_PATH_BIT  = 2;
  localparam int unsigned CTRL_MODE_LSB  = 4;
  localparam int unsigned MODE_W         = 3;

  localparam int unsigned THR_A_LSB = 0;
  localparam int unsigned THR_B_LSB = 8;
  localparam int unsigned CODE_W    = 8;

  localparam int unsigned ST_ATI0_BIT = 0;
  localparam int unsigned ST_ATI1_BIT = 1;
  localparam int unsigned ST_TRIG_BIT = 2;
  localparam int unsigned ST_PIN_BIT  = 3;

  // ************************************************************
  // Threshold codes and reset values
  // ************************************************************
  localparam logic [7:0] CODE_POS_FS = 8'h00;
  localparam logic [7:0] CODE_NEG_FS = 8'hff;
  localparam logic [7:0] THR_A_RST   = CODE_POS_FS;
  localparam logic [7:0] THR_B_RST   = CODE_NEG_FS;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Trigger modes and control carrier
  // ************************************************************
  typedef enum logic [2:0] {
    MODE_LOW_WIN   = 3'b000,
    MODE_HIGH_WIN  = 3'b001,
    MODE_MID_WIN   = 3'b010,
    MODE_RISE      = 3'b011,
    MODE_FALL      = 3'b100,
    MODE_HIGH_HYST = 3'b101,
    MODE_LOW_HYST  = 3'b110,
    MODE_RSVD      = 3'b111
  } atfe_mode_t;

  typedef struct packed {
    atfe_mode_t mode;
    logic       path;
    logic       drive;
    logic       enable;
  } atfe_ctrl_t;

  localparam atfe_ctrl_t CTRL_RST = '{mode: MODE_LOW_WIN, path: 1'b0,
                                      drive: 1'b0, enable: 1'b0};

endpackage

// ===== atfe_trig_detect.sv
`timescale 1ns/1ps
module atfe_trig_detect
  import atfe_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  input  wire logic       above_high_in,
  input  wire logic       above_low_in,
  input  wire atfe_mode_t mode_in,
  input  wire logic       enable_in,
  output logic            trig_out
);

  // ************************************************************
  // Hysteresis state and slope history
  // ************************************************************
  typedef enum logic [0:0] {
    HYS_OFF = 1'b0,
    HYS_ON  = 1'b1
  } atfe_hys_t;

  atfe_hys_t hys_q;
  atfe_hys_t hys_d;
  logic      low_prev_q;
  logic      trig_d;
  logic      rise_w;
  logic      fall_w;

  // Slope detection works on the low-threshold comparison.
  assign rise_w = above_low_in & ~low_prev_q;
  assign fall_w = ~above_low_in & low_prev_q;

  // Hysteresis: arm on one threshold, release on the other.
  always_comb begin
    hys_d = hys_q;
    case (mode_in)
      MODE_HIGH_HYST: begin
        if (above_high_in) begin
          hys_d = HYS_ON;
        end else if (!above_low_in) begin
          hys_d = HYS_OFF;
        end
      end
      MODE_LOW_HYST: begin
        if (!above_low_in) begin
          hys_d = HYS_ON;
        end else if (above_high_in) begin
          hys_d = HYS_OFF;
        end
      end
      default: begin
        hys_d = HYS_OFF;
      end
    endcase
  end

  // Mode decode of the two comparison bits.
  always_comb begin
    case (mode_in)
      MODE_LOW_WIN:   trig_d = ~above_low_in;
      MODE_HIGH_WIN:  trig_d = above_high_in;
      MODE_MID_WIN:   trig_d = above_low_in & ~above_high_in;
      MODE_RISE:      trig_d = rise_w;
      MODE_FALL:      trig_d = fall_w;
      MODE_HIGH_HYST: trig_d = (hys_d == HYS_ON);
      MODE_LOW_HYST:  trig_d = (hys_d == HYS_ON);
      default:        trig_d = 1'b0;
    endcase
  end

  // Detection is held off entirely while triggering is disabled.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !enable_in) begin
      hys_q      <= HYS_OFF;
      low_prev_q <= 1'b0;
      trig_out   <= 1'b0;
    end else begin
      hys_q      <= hys_d;
      low_prev_q <= above_low_in;
      trig_out   <= trig_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_low_hyst_set: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    enable_in && mode_in == MODE_LOW_HYST && !above_low_in |=> trig_out)
    else $error("low hysteresis did not fire below the low threshold");

  a_mid_window: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    enable_in && mode_in == MODE_MID_WIN |=>
      trig_out == ($past(above_low_in) && !$past(above_high_in)))
    else $error("middle window output does not match comparisons");

  a_rise_pulse: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    enable_in && mode_in == MODE_RISE && trig_out |=> !trig_out)
    else $error("rising slope trigger lasted more than one cycle");

endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import atfe_pkg::*;
  logic        clk_sys_in, reset_in, pin, cmp_h, cmp_l, sel, gpath, p2f;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, fi0;
  logic        arvalid, arready, rvalid, rready, ati0, ati1;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_q;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  dac_a, dac_b, pin_lvl, amp_lvl, ca, cb, v;
  logic [7:0]  lv [6];
  logic        ph, pl;
  int          n_fail, n_tests, cnt;

  atfe_front_end uut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .shared_trigger_pin_in(pin),
    .cmp_high_in(cmp_h), .cmp_low_in(cmp_l),
    .threshold_dac_a_out(dac_a), .threshold_dac_b_out(dac_b),
    .source_pin_sel_out(sel), .gain_amp_path_out(gpath),
    .pin_to_fi0_out(p2f), .analog_trig_in0_out(ati0),
    .analog_trig_in1_out(ati1), .function_input_zero_out(fi0));

  atfe_cmp_model cmp (.code_high_in(dac_a), .code_low_in(dac_b),
    .pin_sel_in(sel), .amp_path_in(gpath), .pin_level_in(pin_lvl),
    .amp_level_in(amp_lvl), .cmp_high_out(cmp_h), .cmp_low_out(cmp_l));

  // ************************************************************
  // Clock, checks and bus tasks
  // ************************************************************
  // The clock toggles every 12.5 ns, a half period of the 25 ns period.
  always #12.5 clk_sys_in = ~clk_sys_in;

  // Expected comparator bit for a level against a threshold code.
  function automatic logic above(input logic [7:0] l, input logic [7:0] c);
    return l > (8'hff - c);
  endfunction

  // Expected trigger of the level and window modes.
  function automatic logic exp_lvl(input int m, input logic hi, input logic lo);
    case (m)
      0: return !lo;
      1: return hi;
      2: return lo && !hi;
      default: return 1'b0;
    endcase
  endfunction

  // Compares one result and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Lets a number of edges pass, then waits for outputs to settle.
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // One write; address and data are offered together and held until taken.
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys_in);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys_in);
      if (awvalid && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge clk_sys_in); while (bvalid !== 1'b1);
    chk(bresp, er, "write response");
    bready <= 1'b0;
  endtask

  // One read; the data and response are taken at the edge of rvalid.
  task automatic rd(input logic [31:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clk_sys_in);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk_sys_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys_in); while (rvalid !== 1'b1);
    rd_q = rdata;
    chk(rresp, er, "read response");
    chk(rd_q, ed, "read data");
    rready <= 1'b0;
  endtask

  // Closes the run with the counts and the verdict.
  task automatic stop_test;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    clk_sys_in = 1'b0; reset_in = 1'b1; pin = 1'b0;
    awaddr = '0; wdata = '0; wstrb = '0; araddr = '0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; pin_lvl = '0; amp_lvl = '0;
    n_fail = 0; n_tests = 0;
    void'($urandom(76));
    repeat (10) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    settle(1);
    chk({sel, gpath, p2f, fi0}, 4'h0, "reset routing");
    chk({dac_a, dac_b}, {CODE_POS_FS, CODE_NEG_FS}, "reset codes");
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    rd(ADDR_THRESH, 32'h0000_ff00, RESP_OKAY);
    wr(32'h0000_0010, 32'hffff_ffff, 4'hf, RESP_SLVERR);
    rd(32'h0000_0010, 32'h0, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hffff_ffff, 4'hf, RESP_OKAY);
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    $display("test reset and map done");
    // The drive bit routes the pin to function input zero.
    wr(ADDR_CTRL, 32'h2, 4'hf, RESP_OKAY);
    settle(2);
    chk({sel, gpath, p2f}, 3'b101, "pin routing");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_in);
      pin <= 1'($urandom);
      settle(3);
      chk(fi0, pin, "pin to input zero");
    end
    wr(ADDR_CTRL, 32'h4, 4'hf, RESP_OKAY);
    settle(3);
    chk({sel, gpath, p2f, fi0}, 4'b0100, "gain path");
    $display("test routing done");
    // Random thresholds, a strobed byte, then the synchronised comparators.
    ca = 8'($urandom); cb = 8'($urandom);
    wr(ADDR_THRESH, {16'h0, cb, ca}, 4'h3, RESP_OKAY);
    v = 8'($urandom);
    wr(ADDR_THRESH, {16'hffff, ~cb, v}, 4'h1, RESP_OKAY);
    ca = v;
    settle(1);
    chk({dac_a, dac_b}, {ca, cb}, "threshold codes");
    ph = above(amp_lvl, ca); pl = above(amp_lvl, cb);
    for (int k = 0; k < 12; k++) begin
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      @(posedge clk_sys_in);
      amp_lvl <= v;
      settle(2);
      chk({ati0, ati1}, {ph, pl}, "sync stages");
      ph = above(v, ca); pl = above(v, cb);
      settle(1);
      chk({ati0, ati1}, {ph, pl}, "comparator bits");
    end
    rd(ADDR_STATUS, {28'h0, pin, 1'b0, pl, ph}, RESP_OKAY);
    $display("test comparators done");
    // Level and window modes over three fixed levels.
    wr(ADDR_THRESH, 32'h0000_c040, 4'hf, RESP_OKAY);
    lv = '{8'h10, 8'h80, 8'hf0, 8'h80, 8'h10, 8'h80};
    foreach (lv[i]) begin
      for (int m = 0; m < 8; m++) begin
        if (m inside {0, 1, 2, 7}) begin
          wr(ADDR_CTRL, 32'(m * 16 + 5), 4'hf, RESP_OKAY);
          @(posedge clk_sys_in);
          amp_lvl <= lv[i];
          settle(8);
          chk(fi0, exp_lvl(m, above(lv[i], 8'h40),
              above(lv[i], 8'hc0)), "level mode");
          chk(p2f, 1'b0, "pin released");
        end
      end
    end
    // Hysteresis modes walk the same levels in order.
    for (int m = 5; m < 7; m++) begin
      wr(ADDR_CTRL, 32'h4, 4'hf, RESP_OKAY);
      wr(ADDR_CTRL, 32'(m * 16 + 5), 4'hf, RESP_OKAY);
      foreach (lv[i]) begin
        @(posedge clk_sys_in);
        amp_lvl <= lv[i];
        settle(8);
        ph = (m == 6) ? !(i == 2 || i == 3) : (i == 2 || i == 3);
        chk(fi0, ph, "hysteresis");
      end
      rd(ADDR_STATUS, {28'h0, pin, ph, 2'b10}, RESP_OKAY);
    end
    // With the enable clear, mode 6 gives no trigger.
    wr(ADDR_CTRL, 32'h64, 4'hf, RESP_OKAY);
    settle(8);
    chk(fi0, 1'b0, "detector off");
    // Slopes of the low comparator give a single pulse.
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys_in);
      amp_lvl <= s ? 8'h80 : 8'h10;
      wr(ADDR_CTRL, 32'((3 + s) * 16 + 5), 4'hf, RESP_OKAY);
      settle(8);
      @(posedge clk_sys_in);
      amp_lvl <= s ? 8'h10 : 8'h80;
      cnt = 0;
      repeat (14) begin
        settle(1);
        cnt += (fi0 === 1'b1);
      end
      chk(32'(cnt), 32'h1, "slope pulse");
    end
    $display("test modes done");
    stop_test();
  end
endmodule
